/* hdl/sbcs_pkg.sv */
// package of the two-wire control/status block: offsets, fields, counts
// assumes a 16-bit byte address on the register bus
package sbcs_pkg;
    localparam logic [15:0] SBCS_OFF_CST    = 16'hff64;
    localparam logic [15:0] SBCS_OFF_CFG    = 16'hff70;
    localparam logic [15:0] SBCS_OFF_OWN    = 16'hff74;
    localparam logic [15:0] SBCS_OFF_MST    = 16'hff78;
    localparam logic [7:0]  SBCS_CST_RESET  = 8'h00;
    localparam int          SBCS_BIT_ACT    = 0;
    localparam int          SBCS_BIT_OCC    = 1;
    localparam int          SBCS_BIT_OWN    = 2;
    localparam int          SBCS_BIT_GC     = 3;
    localparam int          SBCS_BIT_SDA    = 4;
    localparam int          SBCS_BIT_PULSE  = 5;
    localparam int          SBCS_BIT_WHICH  = 6;
    localparam int          SBCS_BIT_RES    = 7;
    localparam int          SBCS_CFG_EN     = 0;
    localparam int          SBCS_CFG_GC     = 1;
    localparam int          SBCS_CFG_RES    = 2;
    localparam int          SBCS_OWN_PEN    = 7;
    localparam int          SBCS_OWN_SEN    = 15;
    localparam logic [6:0]  SBCS_RES_ADDR   = 7'h61;
    localparam logic [7:0]  SBCS_GC_BYTE    = 8'h00;
    localparam logic [3:0]  SBCS_ADDR_BITS  = 4'h8;
    localparam logic [1:0]  SBCS_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  SBCS_RESP_SLVERR = 2'h2;
    localparam int          SBCS_CFG_W      = 19;

    typedef enum logic [2:0] {
        SBCS_SEL_NONE = 3'h0,
        SBCS_SEL_CST  = 3'h1,
        SBCS_SEL_CFG  = 3'h2,
        SBCS_SEL_OWN  = 3'h3,
        SBCS_SEL_MST  = 3'h4
    } sbcs_sel_t;

    typedef enum logic [2:0] {
        SBCS_IDLE = 3'b001,
        SBCS_ADDR = 3'b010,
        SBCS_HOLD = 3'b100
    } sbcs_state_t;
endpackage

/* hdl/sbcs_link_if.sv */
// signals between the register side and the bus-line side
// config levels go out, event toggles and held results come back
interface sbcs_link_if;
    logic [18:0] cfg;
    logic        pulse_req;
    logic        pulse_ack;
    logic        start_tgl;
    logic        stop_tgl;
    logic        addr_tgl;
    logic        receiving;
    logic        hit_prim;
    logic        hit_sec;
    logic        hit_gc;
    logic        hit_res;

    modport core (output cfg, output pulse_req, input pulse_ack,
                  input start_tgl, input stop_tgl, input addr_tgl,
                  input receiving, input hit_prim, input hit_sec,
                  input hit_gc, input hit_res);
    modport link (input cfg, input pulse_req, output pulse_ack,
                  output start_tgl, output stop_tgl, output addr_tgl,
                  output receiving, output hit_prim, output hit_sec,
                  output hit_gc, output hit_res);
endinterface

/* hdl/sbcs_link.sv */
// bus-line side: start/stop detect, address byte capture, clock pulse
// runs on the link clock; cfg is quasi-static and synced here
module sbcs_link
    import sbcs_pkg::*;
(
    input  wire logic  link_clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  sda_in,
    input  wire logic  scl_in,
    output logic       scl_oe_out,
    sbcs_link_if.link  lk
);
    logic [1:0]          rst_s_r;
    logic [SBCS_CFG_W-1:0] cfg_m_r, cfg_r;
    logic [1:0]          req_s_r;
    logic                sda_m_r, sda_r, sda_q_r;
    logic                scl_m_r, scl_r, scl_q_r;
    logic                lrst_n, start_ev, stop_ev, rise_ev;
    logic [7:0]          shift_r;
    logic [3:0]          cnt_r;
    logic [1:0]          pulse_r;
    sbcs_state_t         state_r;

    always_ff @(posedge link_clk_in) begin
        rst_s_r <= {rst_s_r[0], rst_n_in};
        cfg_m_r <= lk.cfg;
        cfg_r   <= cfg_m_r;
        req_s_r <= {req_s_r[0], lk.pulse_req};
        sda_m_r <= sda_in;
        sda_r   <= sda_m_r;
        sda_q_r <= sda_r;
        scl_m_r <= scl_in;
        scl_r   <= scl_m_r;
        scl_q_r <= scl_r;
    end

    assign lrst_n   = rst_s_r[1] & cfg_r[SBCS_CFG_EN];
    assign start_ev = scl_r & scl_q_r & sda_q_r & ~sda_r;
    assign stop_ev  = scl_r & scl_q_r & ~sda_q_r & sda_r;
    assign rise_ev  = scl_r & ~scl_q_r;

    // edges flip a toggle so the slower side cannot miss a short event
    always_ff @(posedge link_clk_in) begin
        if (!rst_s_r[1]) begin
            lk.start_tgl <= 1'b0;
            lk.stop_tgl  <= 1'b0;
        end else begin
            if (start_ev)
                lk.start_tgl <= ~lk.start_tgl;
            if (stop_ev)
                lk.stop_tgl <= ~lk.stop_tgl;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (!lrst_n) begin
            state_r      <= SBCS_IDLE;
            shift_r      <= 8'h00;
            cnt_r        <= 4'h0;
            lk.addr_tgl  <= 1'b0;
            lk.hit_prim  <= 1'b0;
            lk.hit_sec   <= 1'b0;
            lk.hit_gc    <= 1'b0;
            lk.hit_res   <= 1'b0;
        end else if (start_ev) begin
            state_r <= SBCS_ADDR;
            cnt_r   <= 4'h0;
        end else if (stop_ev) begin
            state_r <= SBCS_IDLE;
        end else begin
            unique case (state_r)
                SBCS_IDLE: ;
                SBCS_ADDR: if (rise_ev) begin
                    shift_r <= {shift_r[6:0], sda_r};
                    cnt_r   <= cnt_r + 4'h1;
                    if (cnt_r == SBCS_ADDR_BITS - 4'h1) begin
                        state_r     <= SBCS_HOLD;
                        lk.addr_tgl <= ~lk.addr_tgl;
                        lk.hit_prim <= cfg_r[SBCS_OWN_PEN + 3] &
                            (shift_r[6:0] == cfg_r[9:3]);
                        lk.hit_sec  <= cfg_r[SBCS_OWN_SEN + 3] &
                            (shift_r[6:0] == cfg_r[17:11]);
                        lk.hit_gc   <= cfg_r[SBCS_CFG_GC] &
                            ({shift_r[6:0], sda_r} == SBCS_GC_BYTE);
                        lk.hit_res  <= cfg_r[SBCS_CFG_RES] &
                            (shift_r[6:0] == SBCS_RES_ADDR);
                    end
                end
                SBCS_HOLD: ;
            endcase
        end
    end

    assign lk.receiving = (state_r == SBCS_ADDR);

    // one low phase then one released phase, then acknowledge
    always_ff @(posedge link_clk_in) begin
        if (!rst_s_r[1]) begin
            pulse_r      <= 2'h0;
            lk.pulse_ack <= 1'b0;
        end else if (pulse_r == 2'h1) begin
            pulse_r <= 2'h2;
        end else if (pulse_r == 2'h2) begin
            pulse_r      <= 2'h0;
            lk.pulse_ack <= req_s_r[1];
        end else if (req_s_r[1] != lk.pulse_ack) begin
            pulse_r <= 2'h1;
        end
    end

    assign scl_oe_out = (pulse_r == 2'h1);
endmodule

/* hdl/sbcs_top.sv */
// two-wire control/status byte with an axi4-lite register slave
// assumes pins are open drain: scl_out is a constant low when enabled
module sbcs_top
    import sbcs_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        link_clk_in,
    input  wire logic [15:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [15:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic        sda_in,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_out,
    input  wire logic        start_gen_in,
    input  wire logic        mastership_won_in,
    input  wire logic        arb_lost_in
);
    sbcs_link_if lk ();

    function automatic sbcs_sel_t reg_sel(input logic [15:0] a);
        unique case (a)
            SBCS_OFF_CST: reg_sel = SBCS_SEL_CST;
            SBCS_OFF_CFG: reg_sel = SBCS_SEL_CFG;
            SBCS_OFF_OWN: reg_sel = SBCS_SEL_OWN;
            SBCS_OFF_MST: reg_sel = SBCS_SEL_MST;
            default:      reg_sel = SBCS_SEL_NONE;
        endcase
    endfunction

    // axi write capture
    logic [15:0] aw_addr_r;
    logic        aw_have_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_have_r;
    logic        wr_go;
    sbcs_sel_t   wr_sel;

    assign s_axi_awready_out = ~aw_have_r & ~s_axi_bvalid_out;
    assign s_axi_wready_out  = ~w_have_r & ~s_axi_bvalid_out;
    assign wr_go  = aw_have_r & w_have_r & ~s_axi_bvalid_out;
    assign wr_sel = reg_sel(aw_addr_r);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            aw_addr_r <= 16'h0000;
            aw_have_r <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            w_have_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_addr_r <= s_axi_awaddr_in;
                aw_have_r <= 1'b1;
            end else if (wr_go) begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_data_r <= s_axi_wdata_in;
                w_strb_r <= s_axi_wstrb_in;
                w_have_r <= 1'b1;
            end else if (wr_go) begin
                w_have_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= SBCS_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= (wr_sel == SBCS_SEL_NONE) ?
                                SBCS_RESP_SLVERR : SBCS_RESP_OKAY;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    logic cst_wr, cfg_wr, own_wr;
    assign cst_wr = wr_go & (wr_sel == SBCS_SEL_CST) & w_strb_r[0];
    assign cfg_wr = wr_go & (wr_sel == SBCS_SEL_CFG) & w_strb_r[0];
    assign own_wr = wr_go & (wr_sel == SBCS_SEL_OWN);

    // software settings
    logic        enable_r, gc_en_r, res_en_r;
    logic [15:0] own_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            enable_r <= 1'b0;
            gc_en_r  <= 1'b0;
            res_en_r <= 1'b0;
        end else if (cfg_wr) begin
            enable_r <= w_data_r[SBCS_CFG_EN];
            gc_en_r  <= w_data_r[SBCS_CFG_GC];
            res_en_r <= w_data_r[SBCS_CFG_RES];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            own_r <= 16'h0000;
        end else if (own_wr) begin
            if (w_strb_r[0])
                own_r[7:0] <= w_data_r[7:0];
            if (w_strb_r[1])
                own_r[15:8] <= w_data_r[15:8];
        end
    end

    assign lk.cfg = {own_r, res_en_r, gc_en_r, enable_r};

    // crossings from the link side and from the pins
    logic [4:0] ev_m_r, ev_r, ev_q_r;
    logic [1:0] sda_s_r, scl_s_r;
    logic       start_p, stop_p, addr_p, ack_s, recv_s;

    always_ff @(posedge clk_in) begin
        ev_m_r  <= {lk.pulse_ack, lk.start_tgl, lk.stop_tgl,
                    lk.addr_tgl, lk.receiving};
        ev_r    <= ev_m_r;
        ev_q_r  <= ev_r;
        sda_s_r <= {sda_s_r[0], sda_in};
        scl_s_r <= {scl_s_r[0], scl_in};
    end

    assign ack_s   = ev_r[4];
    assign start_p = ev_r[3] ^ ev_q_r[3];
    assign stop_p  = ev_r[2] ^ ev_q_r[2];
    assign addr_p  = ev_r[1] ^ ev_q_r[1];
    assign recv_s  = ev_r[0];

    // master flag
    logic master_r;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enable_r)
            master_r <= 1'b0;
        else if (mastership_won_in)
            master_r <= 1'b1;
        else if (arb_lost_in || stop_p)
            master_r <= 1'b0;
    end

    // status byte
    logic occ_r, own_hit_r, gc_hit_r, res_hit_r, which_r;
    logic pulse_req_r, pulse_busy_r;
    logic activity;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enable_r)
            occ_r <= 1'b0;
        else if (!sda_s_r[1] || !scl_s_r[1] || start_p)
            occ_r <= 1'b1;
        else if (stop_p || (cst_wr && w_data_r[SBCS_BIT_OCC]))
            occ_r <= 1'b0;
    end

    // results change on the same link edge that flips the toggle and hold while it
    // crosses the two sync stages into this domain, so sampling them on the toggle edge is safe
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || !enable_r) begin
            own_hit_r <= 1'b0;
            gc_hit_r  <= 1'b0;
            res_hit_r <= 1'b0;
            which_r   <= 1'b0;
        end else if (addr_p && !master_r) begin
            own_hit_r <= lk.hit_prim | lk.hit_sec;
            gc_hit_r  <= lk.hit_gc;
            res_hit_r <= lk.hit_res;
            which_r   <= lk.hit_sec & ~lk.hit_prim;
        end else if (start_p || stop_p) begin
            own_hit_r <= 1'b0;
            gc_hit_r  <= 1'b0;
            res_hit_r <= 1'b0;
            which_r   <= 1'b0;
        end
    end

    assign activity = enable_r & (start_gen_in | master_r | own_hit_r |
                      gc_hit_r | recv_s);

    // pulse request: toggle handshake, bit stays set until the ack returns
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pulse_req_r  <= 1'b0;
            pulse_busy_r <= 1'b0;
        end else if (pulse_busy_r) begin
            if (ack_s == pulse_req_r)
                pulse_busy_r <= 1'b0;
        end else if (enable_r && cst_wr && w_data_r[SBCS_BIT_PULSE] &&
                     !sda_s_r[1]) begin
            pulse_req_r  <= ~pulse_req_r;
            pulse_busy_r <= 1'b1;
        end
    end

    assign lk.pulse_req = pulse_req_r;

    logic [7:0] cst_val;
    always_comb begin
        cst_val                 = SBCS_CST_RESET;
        cst_val[SBCS_BIT_ACT]   = activity;
        cst_val[SBCS_BIT_OCC]   = occ_r;
        cst_val[SBCS_BIT_OWN]   = own_hit_r;
        cst_val[SBCS_BIT_GC]    = gc_hit_r;
        cst_val[SBCS_BIT_SDA]   = enable_r & sda_s_r[1];
        cst_val[SBCS_BIT_PULSE] = enable_r & pulse_busy_r;
        cst_val[SBCS_BIT_WHICH] = own_hit_r & which_r;
        cst_val[SBCS_BIT_RES]   = res_hit_r;
    end

    // axi read: one-cycle registered answer
    sbcs_sel_t rd_sel;
    assign rd_sel = reg_sel(s_axi_araddr_in);
    assign s_axi_arready_out = ~s_axi_rvalid_out;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= 32'h0000_0000;
            s_axi_rresp_out  <= SBCS_RESP_OKAY;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= SBCS_RESP_OKAY;
            unique case (rd_sel)
                SBCS_SEL_CST: s_axi_rdata_out <= {24'h000000, cst_val};
                SBCS_SEL_CFG: s_axi_rdata_out <=
                    {29'h0000_0000, res_en_r, gc_en_r, enable_r};
                SBCS_SEL_OWN: s_axi_rdata_out <= {16'h0000, own_r};
                SBCS_SEL_MST: s_axi_rdata_out <= {31'h0000_0000, master_r};
                SBCS_SEL_NONE: begin
                    s_axi_rdata_out <= 32'h0000_0000;
                    s_axi_rresp_out <= SBCS_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // scl only ever pulled low; the wire rises through its pull-up
    assign scl_out = 1'b0;

    sbcs_link u_link (
        .link_clk_in (link_clk_in),
        .rst_n_in    (rst_n_in),
        .sda_in      (sda_in),
        .scl_in      (scl_in),
        .scl_oe_out  (scl_oe_out),
        .lk          (lk)
    );
endmodule

/* dv/sbcs_asserts.sv */
// assertion checker for the two-wire control/status block
// bound to sbcs_top from the bench; sees the top ports only
module sbcs_asserts
    import sbcs_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        link_clk_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [15:0] s_axi_araddr_in,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        sda_in,
    input wire logic        scl_out,
    input wire logic        scl_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    sequence s_wr;
        s_axi_awvalid_in && s_axi_awready_out &&
        s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_rd;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    // one link cycle low, then released for at least two
    sequence s_one_pulse;
        scl_oe_out ##1 !scl_oe_out ##1 !scl_oe_out;
    endsequence

    chk_wr_answer: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) s_wr |-> ##[1:2] s_axi_bvalid_out)
        else $error("write response missing");
    chk_rd_answer: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) s_rd |-> ##[1:2] s_axi_rvalid_out)
        else $error("read response missing");
    chk_bvalid_holds: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write response dropped early");
    chk_rdata_holds: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) s_axi_rvalid_out && !s_axi_rready_in
        |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data changed while waiting");
    chk_unmapped_read: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) s_rd and s_axi_araddr_in == 16'h0000
        |-> ##[1:2] (s_axi_rvalid_out && s_axi_rdata_out == 32'h0 &&
        s_axi_rresp_out == SBCS_RESP_SLVERR))
        else $error("unmapped read not refused");
    chk_arready_rule: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) s_axi_arready_out == !s_axi_rvalid_out)
        else $error("read address ready wrong");
    chk_pulse_once: assert property (@(posedge link_clk_in)
        disable iff (!rst_n_in) $rose(scl_oe_out) |-> s_one_pulse)
        else $error("clock pulse not one cycle");
    chk_pulse_sda_low: assert property (@(posedge link_clk_in)
        disable iff (!rst_n_in) $rose(scl_oe_out) |-> !$past(sda_in, 4))
        else $error("clock pulse while data line high");
    chk_drive_low: assert property (@(posedge link_clk_in)
        disable iff (!rst_n_in) scl_oe_out |-> scl_out == 1'b0)
        else $error("clock line driven high");
endmodule

/* dv/sbcs_bus_model.sv */
// line model: another master on the two-wire bus with pull-ups
// assumes the block pulls the clock line low while its enable is high
module sbcs_bus_model (
    input  wire logic link_clk_in,
    input  wire logic scl_oe_in,
    output logic      sda_out,
    output logic      scl_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sda_low_r = 1'b0;
    logic scl_low_r = 1'b0;
    // released lines float up to the pull-up level
    assign sda_out = !sda_low_r;
    assign scl_out = !(scl_low_r || scl_oe_in);
    // six link cycles a phase: a line event needs three link cycles to
    // reach the link state and two more register clocks to be readable
    task automatic step(input logic sl, input logic cl);
        @(posedge link_clk_in);
        sda_low_r <= sl;
        scl_low_r <= cl;
        repeat (5) @(posedge link_clk_in);
    endtask
    task automatic start_c();
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            step(!b[i], 1'b1);
            step(!b[i], 1'b0);
            step(!b[i], 1'b1);
        end
        step(1'b0, 1'b1);
    endtask
    task automatic rstart();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
    endtask
    task automatic stop_c();
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
endmodule

/* dv/tb.sv */
// top bench: axi4-lite master tasks, line model and checker bind
// assumes the line model resolves the open-drain wires
module tb
    import sbcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in, rst_n_in, link_clk_in;
    logic [15:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
    logic        s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
    logic        s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
    logic        s_axi_rready_in, sda_in, scl_in, scl_out, scl_oe_out;
    logic        start_gen_in, mastership_won_in, arb_lost_in;
    logic        oe_q = 1'b0;
    int          pulses = 0;
    int          cycles = 0;
    int          n_fail = 0;
    int          comparisons = 0;
    logic [7:0]  adr_tbl [5] = '{8'h74, 8'h4a, 8'h00, 8'hc2, 8'h20};
    logic [7:0]  exp_tbl [5] = '{8'h17, 8'h57, 8'h1b, 8'h92, 8'h12};
    // activity after a resolution-only hit is left open, so masked
    logic [7:0]  msk_tbl [5] = '{8'hff, 8'hff, 8'hff, 8'hfe, 8'hff};

    sbcs_top u_sbcs_top (.*);
    sbcs_bus_model u_sbcs_bus_model (.link_clk_in(link_clk_in),
        .scl_oe_in(scl_oe_out), .sda_out(sda_in), .scl_out(scl_in));

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        link_clk_in = 1'b0;
        #37;
        forever #80 link_clk_in = ~link_clk_in;
    end
    always @(posedge link_clk_in) begin
        oe_q <= scl_oe_out;
        if (scl_oe_out && !oe_q) begin
            pulses <= pulses + 1;
        end
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        while (aw_p || w_p) begin
            @(negedge clk_in);
            aw_p = aw_p && !s_axi_awready_out;
            w_p = w_p && !s_axi_wready_out;
            @(posedge clk_in);
            s_axi_awvalid_in <= aw_p;
            s_axi_wvalid_in <= w_p;
        end
        do @(negedge clk_in); while (s_axi_bvalid_out !== 1'b1);
        check("bresp", {30'h0, s_axi_bresp_out}, {30'h0, er});
        @(posedge clk_in);
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic axi_rd(input logic [15:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do @(negedge clk_in); while (s_axi_arready_out !== 1'b1);
        @(posedge clk_in);
        s_axi_arvalid_in <= 1'b0;
        do @(negedge clk_in); while (s_axi_rvalid_out !== 1'b1);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        @(posedge clk_in);
        s_axi_rready_in <= 1'b0;
    endtask
    task automatic cst(input logic [7:0] e, input logic [7:0] m);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(SBCS_OFF_CST, d, r);
        check("status", d & {24'h0, m}, {24'h0, e & m});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
        {s_axi_arvalid_in, s_axi_rready_in, start_gen_in} = '0;
        {mastership_won_in, arb_lost_in, rst_n_in} = '0;
        s_axi_wstrb_in = 4'hf;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        cst(8'h00, 8'hff);
        axi_rd(16'h0000, d, r);
        check("rresp", {30'h0, r}, {30'h0, SBCS_RESP_SLVERR});
        axi_wr(16'h0004, 32'h1, SBCS_RESP_SLVERR);
        axi_wr(SBCS_OFF_CFG, 32'h7, SBCS_RESP_OKAY);
        axi_wr(SBCS_OFF_OWN, 32'ha5ba, SBCS_RESP_OKAY);
        cst(8'h10, 8'hff);
        for (int k = 0; k < 5; k++) begin
            u_sbcs_bus_model.start_c();
            u_sbcs_bus_model.send_byte(adr_tbl[k]);
            cst(exp_tbl[k], msk_tbl[k]);
            u_sbcs_bus_model.rstart();
            cst(8'h03, 8'hff);
            u_sbcs_bus_model.stop_c();
            cst(8'h10, 8'hff);
        end
        axi_wr(SBCS_OFF_CST, 32'h20, SBCS_RESP_OKAY);
        cst(8'h10, 8'hff);
        check("pulses", pulses, 32'h0);
        // a slave stuck holding the data line low
        u_sbcs_bus_model.step(1'b1, 1'b0);
        for (int k = 1; k <= 2; k++) begin
            axi_wr(SBCS_OFF_CST, 32'h20, SBCS_RESP_OKAY);
            n = 0;
            do begin
                axi_rd(SBCS_OFF_CST, d, r);
                n++;
            end while ((d[5] !== 1'b0 || pulses != k) && n < 60);
            check("pulses", pulses, k);
            check("status", d & 32'h22, 32'h02);
        end
        u_sbcs_bus_model.stop_c();
        cst(8'h10, 8'hff);
        @(posedge clk_in);
        mastership_won_in <= 1'b1;
        @(posedge clk_in);
        mastership_won_in <= 1'b0;
        axi_rd(SBCS_OFF_MST, d, r);
        check("master", d, 32'h1);
        cst(8'h11, 8'hff);
        @(posedge clk_in);
        arb_lost_in <= 1'b1;
        @(posedge clk_in);
        arb_lost_in <= 1'b0;
        axi_rd(SBCS_OFF_MST, d, r);
        check("master", d, 32'h0);
        cst(8'h10, 8'hff);
        @(posedge clk_in);
        start_gen_in <= 1'b1;
        cst(8'h11, 8'hff);
        start_gen_in <= 1'b0;
        cst(8'h10, 8'hff);
        u_sbcs_bus_model.start_c();
        u_sbcs_bus_model.send_byte(8'h74);
        // both lines high again without a stop: only a write-one or a disable clears
        u_sbcs_bus_model.step(1'b0, 1'b0);
        cst(8'h17, 8'hff);
        axi_wr(SBCS_OFF_CST, 32'h02, SBCS_RESP_OKAY);
        cst(8'h15, 8'hff);
        axi_wr(SBCS_OFF_CFG, 32'h0, SBCS_RESP_OKAY);
        cst(8'h00, 8'hff);
        u_sbcs_bus_model.stop_c();
        tally_and_finish();
    end
endmodule

bind sbcs_top sbcs_asserts u_sbcs_asserts (.*);
